// *** rtl/cycle_timer.sv ***
// down counter that flags a one-cycle expiry after a loaded interval
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 24
)(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  // state
  output logic busy,
  output logic expired
);
  logic [W-1:0] cnt_ff;
  logic expired_ff;

  // a zero interval is treated as one cycle so it still expires
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= (value == '0) ? W'(1) : value;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  // expiry pulse, suppressed by a reload in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= !load && (cnt_ff == W'(1));
    end
  end

  assign busy = (cnt_ff != '0);
  assign expired = expired_ff;
endmodule

// *** rtl/gap_range_encoder.sv ***
// maps a sampled field amplitude onto an eight-step range code
`timescale 1ns/1ps
module gap_range_encoder #(
  parameter int AW = 12,
  parameter int N = 7
)(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // amplitude and ascending thresholds, lowest in the low slice
  input wire logic [AW-1:0] amp,
  input wire logic [N*AW-1:0] thr,
  // registered code
  output logic [2:0] gap_range_code
);
  logic [2:0] nxt_code;
  logic [2:0] code_ff;

  // code counts the thresholds reached: one step per doubling band
  always_comb begin
    nxt_code = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (amp >= thr[i*AW +: AW]) begin
        nxt_code = 3'(i + 1);
      end
    end
  end

  // registered so the word sees a stable code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      code_ff <= 3'h0;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign gap_range_code = code_ff;
endmodule

// *** rtl/wheel_speed_word_encoder.sv ***
// wheel-speed word encoder with standstill, vibration and fault handling
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "wse_defines.svh"
// What this block does
// - gap field holds amplitude range 0..7, one step per doubling band
// - fine labels: events 1-3 give codes 1-3, events 4-6 give 5-7
// - a standstill word follows whenever no word went out and no fault was present for stop time
// - standstill words always use the middle current level
// - eight-event: fine word cutting a standstill pulse waits separation delay
// - while a fault persists the output sits at the fault level
// - after reset a calibration phase runs and learns rotation direction
// - direction marked valid and running only after calibration completes
// - too many reversals without steady runs enter vibration, blanking all but standstill words
// - a steady same-direction run leaves vibration and resumes output
// - four-event: vibration watches the finer step stream, not output events
// - each word is one speed pulse, eight data bits and a parity bit
// - eight-event: gap code on primary words, fine label on fine words
// - four-event: gap code on every word, fine labels unused
// - parity bit is the exclusive-or of the eight data bits
module wheel_speed_word_encoder #(
  parameter int AW = 12
)(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // front end events, amplitude and diagnostics
  input wire logic ev_valid,
  input wse_pkg::fe_event_t ev,
  input wire logic step_valid,
  input wire logic step_dir,
  input wire logic [AW-1:0] field_amplitude,
  input wire logic fault_in,
  // output words and current level
  output logic word_valid,
  output wse_pkg::word_t word,
  output wse_pkg::cur_level_t cur_level,
  // interrupt
  output logic irq,
  // axi4-lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import wse_pkg::*;

  // software registers
  logic eight_ff;
  logic [23:0] stop_time_ff;
  logic [15:0] sep_delay_ff;
  logic [15:0] pulse_len_ff;
  logic [7:0] rev_limit_ff;
  logic [7:0] steady_len_ff;
  logic [7:0] cal_events_ff;
  logic [AW-1:0] lr_thr_ff;
  logic [7*AW-1:0] gap_thr_ff;
  logic [`WSE_INT_W-1:0] int_stat_ff;
  logic [`WSE_INT_W-1:0] int_mask_ff;
  logic [`WSE_INT_W-1:0] int_evt;
  // bus state
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic rd_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [2:0] wr_thr_idx;
  logic [2:0] rd_thr_idx;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  // core state
  cal_state_t cal_state_ff;
  logic [7:0] cal_cnt_ff;
  logic dir_ff;
  logic vib_ff;
  logic vdir_ff;
  logic [7:0] rev_cnt_ff;
  logic [7:0] run_cnt_ff;
  logic pend_ff;
  fe_event_t pend_ev_ff;
  logic ss_ff;
  logic boot_ff;
  word_t word_ff;
  logic word_valid_ff;
  cur_level_t level_ff;
  // core decisions
  logic accept;
  logic hold_fine;
  logic send_ev;
  logic fire_pend;
  logic send_ss;
  logic emit;
  logic vsrc_valid;
  logic vsrc_dir;
  logic vib_enter;
  logic cal_done;
  fe_event_t sel;
  word_t nxt_word;
  logic [2:0] gap_code;
  logic pulse_busy;
  logic pulse_exp;
  logic stop_exp;
  logic sep_exp;

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // both write channels are taken in one beat once no response is pending
  assign wr_go = awvalid && wvalid && !bvalid_ff;
  assign awready = wr_go;
  assign wready = wr_go;
  assign rd_go = arvalid && !rvalid_ff;
  assign arready = rd_go;
  assign wa = {awaddr[7:2], 2'b00};
  assign ra = {araddr[7:2], 2'b00};
  assign wr_ok = (wa <= `WSE_OFF_LAST_WORD) && (wa != `WSE_OFF_STATUS);
  // threshold slot; the four-bit difference wraps so the last slot is 6
  assign wr_thr_idx = 3'(wa[5:2] - 4'(`WSE_OFF_GAP_THR0 >> 2));
  assign rd_thr_idx = 3'(ra[5:2] - 4'(`WSE_OFF_GAP_THR0 >> 2));

  // configuration registers; read-only offsets ignore writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eight_ff <= `WSE_RST_EIGHT;
      stop_time_ff <= `WSE_RST_STOP_TIME;
      sep_delay_ff <= `WSE_RST_SEP_DELAY;
      pulse_len_ff <= `WSE_RST_PULSE_LEN;
      rev_limit_ff <= `WSE_RST_REV_LIMIT;
      steady_len_ff <= `WSE_RST_STEADY_LEN;
      cal_events_ff <= `WSE_RST_CAL_EVENTS;
      lr_thr_ff <= `WSE_RST_LR_THR;
      gap_thr_ff <= `WSE_RST_GAP_THR;
      int_mask_ff <= '0;
    end else if (wr_go) begin
      case (wa)
        `WSE_OFF_CTRL: eight_ff <= 1'(merge(32'(eight_ff), wdata, wstrb));
        `WSE_OFF_INT_MASK: int_mask_ff <=
          `WSE_INT_W'(merge(32'(int_mask_ff), wdata, wstrb));
        `WSE_OFF_STOP_TIME: stop_time_ff <=
          24'(merge(32'(stop_time_ff), wdata, wstrb));
        `WSE_OFF_SEP_DELAY: sep_delay_ff <=
          16'(merge(32'(sep_delay_ff), wdata, wstrb));
        `WSE_OFF_PULSE_LEN: pulse_len_ff <=
          16'(merge(32'(pulse_len_ff), wdata, wstrb));
        `WSE_OFF_VIB_CFG: begin
          rev_limit_ff <= wstrb[0] ? wdata[7:0] : rev_limit_ff;
          steady_len_ff <= wstrb[1] ? wdata[15:8] : steady_len_ff;
        end
        `WSE_OFF_CAL_CFG: cal_events_ff <=
          8'(merge(32'(cal_events_ff), wdata, wstrb));
        `WSE_OFF_LR_THR: lr_thr_ff <=
          AW'(merge(32'(lr_thr_ff), wdata, wstrb));
        default: begin
          if (wa >= `WSE_OFF_GAP_THR0 && wa <= `WSE_OFF_GAP_THR6) begin
            gap_thr_ff[wr_thr_idx * AW +: AW] <= AW'(merge(
              32'(gap_thr_ff[wr_thr_idx * AW +: AW]), wdata, wstrb));
          end
        end
      endcase
    end
  end

  // sticky interrupt flags: an event in the clearing cycle still sets
  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_stat_ff <= '0;
    end else if (wr_go && wa == `WSE_OFF_INT_STAT && wstrb[0]) begin
      int_stat_ff <= (int_stat_ff & ~wdata[`WSE_INT_W-1:0]) | int_evt;
    end else begin
      int_stat_ff <= int_stat_ff | int_evt;
    end
  end

  assign int_evt = {cal_done, fault_in, vib_enter, emit};
  assign irq = |(int_stat_ff & int_mask_ff);

  // write response follows the taken beat by one cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `WSE_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? `WSE_RESP_OKAY : `WSE_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read multiplexer; unmapped offsets answer zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ra)
      `WSE_OFF_CTRL: rd_data = 32'(eight_ff);
      `WSE_OFF_STATUS: rd_data = 32'({ss_ff && pulse_busy, pend_ff, dir_ff,
                                      fault_in, vib_ff,
                                      cal_state_ff == ST_RUN});
      `WSE_OFF_INT_STAT: rd_data = 32'(int_stat_ff);
      `WSE_OFF_INT_MASK: rd_data = 32'(int_mask_ff);
      `WSE_OFF_STOP_TIME: rd_data = 32'(stop_time_ff);
      `WSE_OFF_SEP_DELAY: rd_data = 32'(sep_delay_ff);
      `WSE_OFF_PULSE_LEN: rd_data = 32'(pulse_len_ff);
      `WSE_OFF_VIB_CFG: rd_data = 32'({steady_len_ff, rev_limit_ff});
      `WSE_OFF_CAL_CFG: rd_data = 32'(cal_events_ff);
      `WSE_OFF_LR_THR: rd_data = 32'(lr_thr_ff);
      `WSE_OFF_LAST_WORD: rd_data = 32'(word_ff);
      default: begin
        if (ra >= `WSE_OFF_GAP_THR0 && ra <= `WSE_OFF_GAP_THR6) begin
          rd_data = 32'(gap_thr_ff[rd_thr_idx * AW +: AW]);
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `WSE_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_ok ? `WSE_RESP_OKAY : `WSE_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // amplitude to range code
  gap_range_encoder #(.AW(AW), .N(7)) u_gap (
    .clk(clk),
    .nrst(nrst),
    .amp(field_amplitude),
    .thr(gap_thr_ff),
    .gap_range_code(gap_code)
  );

  // speed pulse duration
  cycle_timer #(.W(24)) u_pulse (
    .clk(clk),
    .nrst(nrst),
    .load(emit),
    .value(24'(pulse_len_ff)),
    .busy(pulse_busy),
    .expired(pulse_exp)
  );

  // silence watchdog, rearmed by every word, by a fault and after reset
  cycle_timer #(.W(24)) u_stop (
    .clk(clk),
    .nrst(nrst),
    .load(emit || fault_in || boot_ff),
    .value(stop_time_ff),
    .busy(),
    .expired(stop_exp)
  );

  // postponement of a fine word behind a standstill pulse
  cycle_timer #(.W(24)) u_sep (
    .clk(clk),
    .nrst(nrst),
    .load(hold_fine),
    .value(24'(sep_delay_ff)),
    .busy(),
    .expired(sep_exp)
  );

  // word selection; a fault blanks all words, vibration blanks all but standstill words
  assign accept = ev_valid && !vib_ff && !fault_in;
  assign hold_fine = accept && eight_ff && ev.fine && ss_ff &&
                     pulse_busy;
  assign send_ev = accept && !hold_fine;
  assign fire_pend = pend_ff && sep_exp && !vib_ff && !fault_in &&
                     !send_ev;
  assign send_ss = stop_exp && !send_ev && !fire_pend && !fault_in;
  assign emit = send_ev || fire_pend || send_ss;
  assign sel = send_ev ? ev : pend_ev_ff;

  // assemble speed level, data bits and parity
  always_comb begin
    nxt_word = '0;
    nxt_word.level = LVL_HIGH;
    nxt_word.data[`WSE_BIT_LR] = (field_amplitude < lr_thr_ff);
    nxt_word.data[`WSE_BIT_M] = (cal_state_ff != ST_RUN);
    nxt_word.data[`WSE_BIT_GDR] = (cal_state_ff == ST_RUN);
    nxt_word.data[`WSE_BIT_DR] = send_ss ? dir_ff : sel.dir;
    nxt_word.data[`WSE_BIT_PI] = 1'b1;
    nxt_word.data[`WSE_BIT_FLD_LO +: 3] = gap_code;
    if (send_ss) begin
      nxt_word.level = LVL_MID;
    end else if (sel.fine) begin
      nxt_word.data[`WSE_BIT_PI] = 1'b0;
      if (eight_ff) begin
        nxt_word.level = LVL_MID;
        // labels skip code 4 so 4 never appears; index 0 gives 0 and index 7 wraps to 0
        nxt_word.data[`WSE_BIT_FLD_LO +: 3] = (sel.index > 3'h3) ?
          sel.index + 3'h1 : sel.index;
      end
    end
    // eight data bits plus parity after the speed pulse
    nxt_word.data[`WSE_BIT_PAR] = ^nxt_word.data[7:0];
  end

  // output word register and one-cycle strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      word_ff <= '0;
      word_valid_ff <= 1'b0;
      ss_ff <= 1'b0;
    end else begin
      word_valid_ff <= emit;
      if (emit) begin
        word_ff <= nxt_word;
        ss_ff <= send_ss;
      end
    end
  end

  // current level: fault overrides, speed level lasts the pulse length
  always_ff @(posedge clk) begin
    if (!nrst) begin
      level_ff <= LVL_LOW;
    end else if (fault_in) begin
      level_ff <= LVL_FAULT;
    end else if (emit) begin
      level_ff <= nxt_word.level;
    end else if (pulse_exp || level_ff == LVL_FAULT) begin
      level_ff <= LVL_LOW;
    end
  end

  // held fine event; a fresh event in the release cycle displaces it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      pend_ev_ff <= '0;
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
      if (hold_fine) begin
        pend_ff <= 1'b1;
        pend_ev_ff <= ev;
      end else if (sep_exp || fault_in || vib_ff) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // calibration counts events and tracks direction before running
  assign cal_done = (cal_state_ff == ST_CAL) && ev_valid && !fault_in &&
                    (cal_cnt_ff + 8'h01 >= cal_events_ff);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cal_state_ff <= ST_CAL;
      cal_cnt_ff <= 8'h00;
      dir_ff <= 1'b0;
    end else begin
      if (ev_valid && !fault_in) begin
        dir_ff <= ev.dir;
      end
      case (cal_state_ff)
        ST_CAL: begin
          if (ev_valid && !fault_in) begin
            cal_cnt_ff <= cal_cnt_ff + 8'h01;
          end
          if (cal_done) begin
            cal_state_ff <= ST_RUN;
          end
        end
        ST_RUN: cal_state_ff <= ST_RUN;
        default: cal_state_ff <= ST_CAL;
      endcase
    end
  end

  // vibration source: finer steps in the four-event variant
  assign vsrc_valid = eight_ff ? (ev_valid && !fault_in) : step_valid;
  assign vsrc_dir = eight_ff ? ev.dir : step_dir;
  assign vib_enter = vsrc_valid && !vib_ff && (vsrc_dir != vdir_ff) &&
                     (run_cnt_ff < steady_len_ff) &&
                     (rev_cnt_ff + 8'h01 >= rev_limit_ff);

  // reversal and steady-run counting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vib_ff <= 1'b0;
      vdir_ff <= 1'b0;
      rev_cnt_ff <= 8'h00;
      run_cnt_ff <= 8'h00;
    end else if (vsrc_valid) begin
      if (vsrc_dir != vdir_ff) begin
        vdir_ff <= vsrc_dir;
        run_cnt_ff <= 8'h01;
        if (vib_enter) begin
          vib_ff <= 1'b1;
          rev_cnt_ff <= 8'h00;
        end else if (!vib_ff) begin
          // a long steady run before this reversal restarts the tally
          rev_cnt_ff <= (run_cnt_ff >= steady_len_ff) ? 8'h01 :
                        rev_cnt_ff + 8'h01;
        end
      end else begin
        run_cnt_ff <= (run_cnt_ff == 8'hFF) ? 8'hFF : run_cnt_ff + 8'h01;
        if (vib_ff && run_cnt_ff + 8'h01 >= steady_len_ff) begin
          vib_ff <= 1'b0;
          rev_cnt_ff <= 8'h00;
        end
      end
    end
  end

  assign word_valid = word_valid_ff;
  assign word = word_ff;
  assign cur_level = level_ff;
endmodule

// *** rtl/wse_defines.svh ***
// register offsets, field positions, reset values and fixed codes
`ifndef WSE_DEFINES_SVH
`define WSE_DEFINES_SVH

// register byte offsets
`define WSE_OFF_CTRL      8'h00
`define WSE_OFF_STATUS    8'h04
`define WSE_OFF_INT_STAT  8'h08
`define WSE_OFF_INT_MASK  8'h0C
`define WSE_OFF_STOP_TIME 8'h10
`define WSE_OFF_SEP_DELAY 8'h14
`define WSE_OFF_PULSE_LEN 8'h18
`define WSE_OFF_VIB_CFG   8'h1C
`define WSE_OFF_CAL_CFG   8'h20
`define WSE_OFF_LR_THR    8'h24
`define WSE_OFF_GAP_THR0  8'h28
`define WSE_OFF_GAP_THR6  8'h40
`define WSE_OFF_LAST_WORD 8'h44

// data bit positions inside the nine-bit word
`define WSE_BIT_LR     0
`define WSE_BIT_M      1
`define WSE_BIT_PI     2
`define WSE_BIT_GDR    3
`define WSE_BIT_DR     4
`define WSE_BIT_FLD_LO 5
`define WSE_BIT_PAR    8

// interrupt status bits
`define WSE_INT_WORD  0
`define WSE_INT_VIB   1
`define WSE_INT_FAULT 2
`define WSE_INT_CAL   3
`define WSE_INT_W     4

// reset values
`define WSE_RST_EIGHT      1'b1
`define WSE_RST_STOP_TIME  24'h0F4240
`define WSE_RST_SEP_DELAY  16'h0FA0
`define WSE_RST_PULSE_LEN  16'h07D0
`define WSE_RST_REV_LIMIT  8'h03
`define WSE_RST_STEADY_LEN 8'h04
`define WSE_RST_CAL_EVENTS 8'h04
`define WSE_RST_LR_THR     12'h024

// gap range thresholds, amplitude in units of 0.1 G, ascending
`define WSE_RST_GAP_THR {12'hE10, 12'h708, 12'h384, 12'h1C2, 12'h0DC, 12'h06E, 12'h038}

// bus answers
`define WSE_RESP_OKAY   2'h0
`define WSE_RESP_SLVERR 2'h2

`endif

// *** rtl/wse_pkg.sv ***
// types shared by the word encoder and its helpers
package wse_pkg;
  // current level on the two-wire output
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH, LVL_FAULT} cur_level_t;
  // start-up calibration state
  typedef enum logic {ST_CAL, ST_RUN} cal_state_t;
  // one event from the front end
  typedef struct packed {
    logic fine;
    logic [2:0] index;
    logic dir;
  } fe_event_t;
  // one output word: speed pulse level plus nine data bits
  typedef struct packed {
    cur_level_t level;
    logic [8:0] data;
  } word_t;
endpackage

// *** tb/ecu_model.sv ***
// control-unit side model: receives and counts current-loop words
`timescale 1ns/1ps
module ecu_model
  import wse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // words from the sensor
  input wire logic word_valid,
  input word_t word,
  // received tally
  output int n_words
);
  // the receiver only counts; blanking shows up as a tally that stands still
  always_ff @(posedge clk) begin
    if (!nrst) begin
      n_words <= 0;
    end else if (word_valid && word.level != LVL_FAULT) begin
      n_words <= n_words + 1;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the wheel-speed word encoder
`timescale 1ns/1ps
`include "wse_defines.svh"
module tb_top;
  import wse_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ev_valid = 1'b0;
  fe_event_t ev = '0;
  logic step_valid = 1'b0;
  logic step_dir = 1'b0;
  logic [11:0] field_amplitude = 12'h000;
  logic fault_in = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic word_valid, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  word_t word;
  cur_level_t cur_level;
  int n_fail = 0;
  int n_checks = 0;
  int n_words, n0, k, c;
  logic [18:0] rows [15];
  wire [4:0] hsk = {word_valid, rvalid, arready, bvalid, awready & wready};

  wheel_speed_word_encoder u_dut (.clk, .nrst, .ev_valid, .ev, .step_valid,
    .step_dir, .field_amplitude, .fault_in, .word_valid, .word, .cur_level,
    .irq, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp);
  ecu_model u_ecu (.clk, .nrst, .word_valid, .word, .n_words);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task results;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits for one handshake line, checked just after each edge
  task hold(input int s, input int lim);
    for (k = 0; k < lim; k++) begin
      #1;
      if (hsk[s] === 1'b1) break;
      @(posedge clk);
    end
    c = k;
    if (k == lim) begin
      n_fail++;
      results();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    hold(0, 200);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hold(1, 200);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    hold(2, 200);
    @(posedge clk);
    arvalid <= 1'b0;
    hold(3, 200);
    rd = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // one-cycle strobe on the event or the fine step input
  task pulse(input logic st, input logic f, input logic [2:0] i,
    input logic d);
    @(posedge clk);
    if (st) begin
      step_valid <= 1'b1;
      step_dir <= d;
    end else begin
      ev_valid <= 1'b1;
      ev <= '{fine: f, index: i, dir: d};
    end
    @(posedge clk);
    ev_valid <= 1'b0;
    step_valid <= 1'b0;
  endtask

  // reversals with no steady run blank words until a steady run is seen
  task vib(input logic st);
    for (int j = 0; j < 6; j++) pulse(st, 1'b0, 3'h0, j[0]);
    repeat (8) @(posedge clk);
    n0 = n_words;
    pulse(1'b0, 1'b0, 3'h0, 1'b1);
    repeat (4) @(posedge clk);
    chk(n_words - n0, 0);
    for (int j = 0; j < 5; j++) pulse(st, 1'b0, 3'h0, 1'b1);
    repeat (8) @(posedge clk);
    pulse(1'b0, 1'b0, 3'h0, 1'b1);
    hold(4, 4);
    chk(c, 0);
  endtask

  initial begin
    // {fine, index, amplitude, expected field}: range edges, then labels
    rows = '{{1'b0, 3'h0, 12'h023, 3'h0}, {1'b0, 3'h0, 12'h037, 3'h0},
      {1'b0, 3'h0, 12'h038, 3'h1}, {1'b0, 3'h0, 12'h06E, 3'h2},
      {1'b0, 3'h0, 12'h0DC, 3'h3}, {1'b0, 3'h0, 12'h1C2, 3'h4},
      {1'b0, 3'h0, 12'h384, 3'h5}, {1'b0, 3'h0, 12'h708, 3'h6},
      {1'b0, 3'h0, 12'hE10, 3'h7}, {1'b1, 3'h1, 12'hE10, 3'h1},
      {1'b1, 3'h2, 12'hE10, 3'h2}, {1'b1, 3'h3, 12'hE10, 3'h3},
      {1'b1, 3'h4, 12'hE10, 3'h5}, {1'b1, 3'h5, 12'hE10, 3'h6},
      {1'b1, 3'h6, 12'hE10, 3'h7}};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk({word_valid, word, cur_level, irq}, 0);
    rdr(`WSE_OFF_STOP_TIME);
    chk(rd, `WSE_RST_STOP_TIME);
    wr(`WSE_OFF_PULSE_LEN, 32'h4);
    wr(`WSE_OFF_SEP_DELAY, 32'h8);
    wr(`WSE_OFF_STOP_TIME, 32'h3C);
    for (int r = 0; r < 15; r++) begin
      @(posedge clk);
      field_amplitude <= rows[r][14:3];
      repeat (2) @(posedge clk);
      pulse(1'b0, rows[r][18], rows[r][17:15], 1'b1);
      hold(4, 4);
      chk({word.level, word.data[7:5], word.data[2], word.data[0],
        word.data[4]}, {rows[r][18] ? LVL_MID : LVL_HIGH, rows[r][2:0],
        !rows[r][18], rows[r][14:3] < 12'h024, 1'b1});
      if (r == 0) chk({word.data[3], word.data[1]}, 2'b01);
    end
    chk({word.data[3], word.data[1]}, 2'b10);
    @(posedge clk);
    hold(4, 100);
    chk(c >= 55 && c <= 65, 1'b1);
    chk({word.level, word.data[2]}, {LVL_MID, 1'b1});
    pulse(1'b0, 1'b1, 3'h2, 1'b1);
    hold(4, 20);
    chk({c >= 7 && c <= 10, word.data[7:5]}, 4'hA);
    wr(`WSE_OFF_CTRL, 32'h0);
    pulse(1'b0, 1'b1, 3'h4, 1'b1);
    hold(4, 4);
    chk({word.level, word.data[7:5], word.data[2]}, {LVL_HIGH, 4'hE});
    vib(1'b1);
    wr(`WSE_OFF_CTRL, 32'h1);
    vib(1'b0);
    rdr(`WSE_OFF_INT_STAT);
    chk(rd[1], 1'b1);
    // fault with the interrupt first masked, then unmasked, then cleared
    wr(`WSE_OFF_INT_STAT, 32'hF);
    @(posedge clk);
    fault_in <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({cur_level, irq}, {LVL_FAULT, 1'b0});
    n0 = n_words;
    pulse(1'b0, 1'b0, 3'h0, 1'b1);
    wr(`WSE_OFF_INT_MASK, 32'h4);
    chk({irq, n_words == n0}, 2'b11);
    @(posedge clk);
    fault_in <= 1'b0;
    wr(`WSE_OFF_INT_STAT, 32'h4);
    #1;
    chk(irq, 1'b0);
    rdr(8'h48);
    chk({rs, rd}, {`WSE_RESP_SLVERR, 32'h0});
    wr(`WSE_OFF_STATUS, 32'h1);
    chk(rs, `WSE_RESP_SLVERR);
    // byte lanes: only the enabled lane of the top threshold changes
    wstrb <= 4'h1;
    wr(`WSE_OFF_GAP_THR6, 32'h0000_0F99);
    rdr(`WSE_OFF_GAP_THR6);
    chk(rd, 32'h0000_0E99);
    results();
  end
endmodule

// *** tb/wse_checker_assertions.sv ***
// port-level assertions for the wheel-speed word encoder
`timescale 1ns/1ps
module wse_checker
  import wse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // event and word side
  input wire logic ev_valid,
  input wire logic fault_in,
  input wire logic word_valid,
  input word_t word,
  input cur_level_t cur_level,
  // register bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_parity_xor: assert property (
    word_valid |-> word.data[8] == ^word.data[7:0])
    else $error("parity bit disagrees with data bits");
  a_fine_label: assert property (
    word_valid && word.level == LVL_MID && !word.data[2] |->
    word.data[7:5] != 3'h0 && word.data[7:5] != 3'h4)
    else $error("fine word carries an unused label");
  a_standstill_mid: assert property (
    word_valid && !$past(ev_valid) && word.data[2] |->
    word.level == LVL_MID)
    else $error("standstill word not at middle level");
  a_fault_level: assert property (
    fault_in |=> cur_level == LVL_FAULT)
    else $error("fault not held at fault level");
  a_word_level: assert property (
    word_valid && !$past(fault_in) |-> cur_level == word.level)
    else $error("speed pulse level differs from word level");
  a_dir_valid_run: assert property (
    word_valid && word.data[3] |-> !word.data[1])
    else $error("direction valid before running mode");
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid)
    else $error("read data late");

  // main scenarios seen at the ports
  c_standstill: cover property (word_valid && word.level == LVL_MID &&
    word.data[2]);
  c_fault: cover property (fault_in ##1 cur_level == LVL_FAULT);
  c_held: cover property (word_valid && !word.data[2] && !$past(ev_valid));
endmodule

bind wheel_speed_word_encoder wse_checker u_chk (.clk, .nrst, .ev_valid,
  .fault_in, .word_valid, .word, .cur_level, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid);
